// ==== common/pcpt_pkg.sv ====
// Constants and types for the protection configuration and peak telemetry block
package pcpt_pkg;
   // Command codes of the register set
   localparam logic [7:0] CMD_PROT_CFG = 8'hd0;
   localparam logic [7:0] CMD_PEAK_VIN = 8'hd1;
   localparam logic [7:0] CMD_PEAK_IOUT = 8'hd2;
   localparam logic [7:0] CMD_PEAK_PIN = 8'hd3;
   localparam logic [7:0] CMD_PEAK_TEMP = 8'hd4;
   localparam logic [7:0] CMD_PEAK_RESET = 8'hd5;
   localparam logic [7:0] CMD_AVG_CFG = 8'hdd;

   // Widths and reset values
   localparam int DATA_W = 16;
   localparam int PEAK_W = 10;
   localparam logic [15:0] PROT_CFG_RESET = 16'h0000;
   localparam logic [7:0] AVG_CFG_RESET = 8'h00;
   localparam logic [15:0] RD_ZERO = 16'h0000;

   // Field positions inside the protection configuration and averaging words
   localparam int SS_CFG_LSB = 11;
   localparam int IADC_DIS_BIT = 13;
   localparam int OCP_FILT_LSB = 14;
   localparam int AVG_SEL_MSB = 3;

   // Averaging window: 2**code samples, code clamped to this
   localparam int MAX_AVG_LOG2 = 7;
   localparam logic [3:0] MAX_AVG_CODE = 4'h7;

   // Timing, figures in their own units
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEGL_1US_NS = 1000;
   localparam int DEGL_2US_NS = 2000;
   localparam int DEGL_10US_NS = 10000;
   localparam int SS_STEP_MS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int DEGL_1US_CYC = (DEGL_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGL_2US_CYC = (DEGL_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGL_10US_CYC = (DEGL_10US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SS_STEP_CYC = (SS_STEP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEGL_CNT_W = 12;
   localparam int SS_CNT_W = 23;

   // Soft-start sequencer states
   typedef enum logic [0:0] {
      SS_IDLE = 1'b0,
      SS_WAIT = 1'b1
   } pcpt_ss_e;
endpackage : pcpt_pkg

// ==== common/pcpt_ocp_if.sv ====
// Link between the top and the severe overcurrent deglitch filter
`timescale 1ns/10ps
interface pcpt_ocp_if;
   logic [1:0] filterCode;
   logic ocRaw;
   logic trip;
   modport ctrl (output filterCode, output ocRaw, input trip);
   modport filt (input filterCode, input ocRaw, output trip);
endinterface : pcpt_ocp_if

// ==== hw/pcpt_deglitch.sv ====
// Severe overcurrent deglitch filter with selectable hold time
`timescale 1ns/10ps
module pcpt_deglitch (
   input wire logic clk, // 250 MHz clock
   input wire logic reset, // Synchronous, active high
   pcpt_ocp_if.filt ocp // Code, raw comparator, trip
);
   logic [pcpt_pkg::DEGL_CNT_W-1:0] cnt_reg, cnt_next;
   logic trip_reg, trip_next;
   logic ocpS1_reg, ocpS2_reg, ocpS3_reg, ocpStable_reg, ocpStable_next;

   // Comparator sync: third stage must agree with second before it counts
   always_comb begin
      ocpStable_next = (ocpS2_reg == ocpS3_reg) ? ocpS3_reg : ocpStable_reg;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ocpS1_reg <= 1'b0;
         ocpS2_reg <= 1'b0;
         ocpS3_reg <= 1'b0;
         ocpStable_reg <= 1'b0;
      end else begin
         ocpS1_reg <= ocp.ocRaw;
         ocpS2_reg <= ocpS1_reg;
         ocpS3_reg <= ocpS2_reg;
         ocpStable_reg <= ocpStable_next;
      end
   end

   // Hold time per code
   function automatic logic [pcpt_pkg::DEGL_CNT_W-1:0] hold_cycles(input logic [1:0] code);
      unique case (code)
         2'h0: hold_cycles = '0;
         2'h1: hold_cycles = pcpt_pkg::DEGL_CNT_W'(pcpt_pkg::DEGL_1US_CYC);
         2'h2: hold_cycles = pcpt_pkg::DEGL_CNT_W'(pcpt_pkg::DEGL_2US_CYC);
         2'h3: hold_cycles = pcpt_pkg::DEGL_CNT_W'(pcpt_pkg::DEGL_10US_CYC);
      endcase
   endfunction : hold_cycles

   // A drop of the comparator for two or more clock samples restarts the count, so pulses shorter than the selected hold time never trip
   always_comb begin
      cnt_next = cnt_reg;
      trip_next = trip_reg;
      if (!ocpStable_reg) begin
         cnt_next = '0;
         trip_next = 1'b0;
      end else if (cnt_reg >= hold_cycles(ocp.filterCode)) begin // [RULE8]
         trip_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= '0;
         trip_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         trip_reg <= trip_next;
      end
   end

   assign ocp.trip = trip_reg;

   property p_degl_zero;
      @(posedge clk) disable iff (reset)
      (ocp.filterCode == 2'h0 && ocpStable_reg) |=> ocp.trip;
   endproperty
   a_degl_zero: assert property (p_degl_zero) else $error("Zero deglitch did not trip"); // [RULE8]

   property p_degl_one;
      @(posedge clk) disable iff (reset)
      (ocp.filterCode == 2'h1 && $rose(ocpStable_reg) && !ocp.trip) |=> !ocp.trip [*8];
   endproperty
   a_degl_one: assert property (p_degl_one) else $error("Deglitch tripped too early"); // [RULE8]
endmodule : pcpt_deglitch

// ==== hw/pcpt_top.sv ====
// Protection configuration, averaging and peak telemetry register set
//
// Function
// RULE1: Configuration word resets to all zeros.
// RULE2: Averaging register uses low four bits only.
// RULE3: Low field picks averaged sample count.
// RULE4: Four 10-bit peak registers, direct format.
// RULE5: Send-byte D5h or reset clears peaks.
// RULE6: Readings returned as 2-byte two's-complement words.
// RULE7: Host scales readings with slope, offset, exponent.
// RULE8: Two-bit field sets severe overcurrent deglitch.
// RULE9: Current ADC runs while disable bit zero.
// RULE10: Two-bit field sets soft-start delay.
// RULE11: Peaks rise only on larger measurement.
// RULE12: Current ADC disabled freezes current, power.
`timescale 1ns/10ps
module pcpt_top #(
   parameter int SS_STEP_CYCLES = pcpt_pkg::SS_STEP_CYC // Cycles per 10 ms soft-start step
) (
   input wire logic clk, // 250 MHz clock
   input wire logic reset, // Synchronous, active high
   input wire logic cmdValid, // Decoded bus command strobe
   input wire logic cmdWrite, // 1 write word or send byte, 0 read
   input wire logic cmdSendByte, // Command carries no data
   input wire logic [7:0] cmdCode, // Command code
   input wire logic [15:0] cmdWrData, // Write data, low byte first on bus
   output logic [15:0] rdData, // Read data word
   output logic respValid, // One-cycle answer strobe
   output logic respError, // Command not supported
   input wire logic sampleValid, // New conversion set
   input wire logic [9:0] vinSample, // Input voltage sample
   input wire logic [9:0] ioutSample, // Output current sample
   input wire logic [9:0] pinSample, // Input power sample
   input wire logic [9:0] tempSample, // Temperature sample
   output logic [9:0] vinAvg, // Averaged input voltage
   output logic [9:0] ioutAvg, // Averaged output current
   output logic [9:0] pinAvg, // Averaged input power
   output logic iadcRun, // Current ADC enable
   input wire logic severeOcRaw, // Asynchronous severe overcurrent comparator
   output logic severeOcTrip, // Deglitched severe overcurrent
   input wire logic startReq, // Start request pulse
   output logic softStartGo // Pulse when soft-start delay ends
);
   localparam int ACC_W = pcpt_pkg::PEAK_W + pcpt_pkg::MAX_AVG_LOG2;
   localparam int NCH = 4; // 0 vin, 1 iout, 2 pin, 3 temp

   if (SS_STEP_CYCLES < 1 || 2 * SS_STEP_CYCLES >= (1 << pcpt_pkg::SS_CNT_W)) begin : g_chk
      $error("SS_STEP_CYCLES out of range");
   end

   // Register file
   logic [15:0] protCfg_reg, protCfg_next;
   logic [7:0] avgCfg_reg, avgCfg_next;
   logic [15:0] rdData_reg, rdData_next;
   logic respValid_reg, respValid_next, respError_reg, respError_next;
   logic clearPeaks;
   logic iadcDis;
   logic avgRestart;
   logic [NCH-1:0][9:0] peak_reg, peak_next;
   assign iadcDis = protCfg_reg[pcpt_pkg::IADC_DIS_BIT];
   // An accepted averaging write restarts the window
   assign avgRestart = cmdValid && cmdWrite && !cmdSendByte && cmdCode == pcpt_pkg::CMD_AVG_CFG;
   // Command decode; unknown codes and writes to read-only peaks are refused
   always_comb begin
      protCfg_next = protCfg_reg;
      avgCfg_next = avgCfg_reg;
      rdData_next = rdData_reg;
      respValid_next = cmdValid;
      respError_next = 1'b0;
      clearPeaks = 1'b0;
      if (cmdValid) begin
         if (cmdWrite && cmdSendByte) begin
            if (cmdCode == pcpt_pkg::CMD_PEAK_RESET) begin
               clearPeaks = 1'b1; // [RULE5]
            end else begin
               respError_next = 1'b1;
            end
         end else if (cmdWrite) begin
            unique case (cmdCode)
               pcpt_pkg::CMD_PROT_CFG: protCfg_next = cmdWrData;
               pcpt_pkg::CMD_AVG_CFG: avgCfg_next = {4'h0, cmdWrData[pcpt_pkg::AVG_SEL_MSB:0]}; // [RULE2]
               default: respError_next = 1'b1;
            endcase
         end else begin
            rdData_next = pcpt_pkg::RD_ZERO;
            // Peaks zero-extend to a 2-byte two's-complement word
            unique case (cmdCode)
               pcpt_pkg::CMD_PROT_CFG: rdData_next = protCfg_reg;
               pcpt_pkg::CMD_AVG_CFG: rdData_next = {8'h00, avgCfg_reg};
               pcpt_pkg::CMD_PEAK_VIN: rdData_next = {6'h00, peak_reg[0]}; // [RULE6]
               pcpt_pkg::CMD_PEAK_IOUT: rdData_next = {6'h00, peak_reg[1]}; // [RULE6]
               pcpt_pkg::CMD_PEAK_PIN: rdData_next = {6'h00, peak_reg[2]}; // [RULE6]
               pcpt_pkg::CMD_PEAK_TEMP: rdData_next = {6'h00, peak_reg[3]}; // [RULE6]
               default: respError_next = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         protCfg_reg <= pcpt_pkg::PROT_CFG_RESET; // [RULE1]
         avgCfg_reg <= pcpt_pkg::AVG_CFG_RESET;
         rdData_reg <= pcpt_pkg::RD_ZERO;
         respValid_reg <= 1'b0;
         respError_reg <= 1'b0;
      end else begin
         protCfg_reg <= protCfg_next;
         avgCfg_reg <= avgCfg_next;
         rdData_reg <= rdData_next;
         respValid_reg <= respValid_next;
         respError_reg <= respError_next;
      end
   end
   // Averaging window length as a power of two
   function automatic logic [3:0] avg_log2(input logic [7:0] cfg);
      avg_log2 = (cfg[pcpt_pkg::AVG_SEL_MSB:0] > pcpt_pkg::MAX_AVG_CODE) ?
         pcpt_pkg::MAX_AVG_CODE : cfg[pcpt_pkg::AVG_SEL_MSB:0];
   endfunction : avg_log2

   logic [pcpt_pkg::MAX_AVG_LOG2-1:0] sampCnt_reg, sampCnt_next;
   logic [2:0][ACC_W-1:0] acc_reg, acc_next;
   logic [2:0][9:0] avg_reg, avg_next;
   logic [3:0] avgShift;
   logic windowDone;
   logic [NCH-1:0] chUpd;
   logic [NCH-1:0][9:0] chVal;
   logic [2:0][9:0] smp;

   assign avgShift = avg_log2(avgCfg_reg); // [RULE3]
   assign smp = {pinSample, ioutSample, vinSample};
   assign windowDone = sampleValid &&
      ({1'b0, sampCnt_reg} == (8'(1) << avgShift) - 8'(1));

   // Accumulate, then divide by shifting; current and power hold when the ADC is off
   always_comb begin
      logic [ACC_W-1:0] sum;
      sum = '0;
      sampCnt_next = sampCnt_reg;
      acc_next = acc_reg;
      avg_next = avg_reg;
      if (sampleValid) begin
         sampCnt_next = windowDone ? '0 : sampCnt_reg + 1'b1;
      end
      for (int ch = 0; ch < 3; ch++) begin
         sum = acc_reg[ch] + ACC_W'(smp[ch]);
         if (sampleValid && !(iadcDis && ch != 0)) begin // [RULE12]
            acc_next[ch] = windowDone ? '0 : sum;
            if (windowDone) begin
               avg_next[ch] = pcpt_pkg::PEAK_W'(sum >> avgShift); // [RULE3]
            end
         end
      end
      // A stale partial sum must never be scaled by a new length
      if (avgRestart) begin
         sampCnt_next = '0;
         acc_next = '0;
      end
   end
   // Peak candidates: averaged readings at window end, temperature per sample
   always_comb begin
      for (int ch = 0; ch < 3; ch++) begin
         chUpd[ch] = windowDone && !(iadcDis && ch != 0); // [RULE12]
         chVal[ch] = avg_next[ch];
      end
      chUpd[3] = sampleValid;
      chVal[3] = tempSample;
   end

   // A sample landing with the clear survives it instead of being lost
   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         peak_next[ch] = peak_reg[ch];
         if (clearPeaks) begin
            peak_next[ch] = chUpd[ch] ? chVal[ch] : '0; // [RULE5]
         end else if (chUpd[ch] && chVal[ch] > peak_reg[ch]) begin
            peak_next[ch] = chVal[ch]; // [RULE11] [RULE4]
         end
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         sampCnt_reg <= '0;
         acc_reg <= '0;
         avg_reg <= '0;
         peak_reg <= '0; // [RULE5]
      end else begin
         sampCnt_reg <= sampCnt_next;
         acc_reg <= acc_next;
         avg_reg <= avg_next;
         peak_reg <= peak_next;
      end
   end

   // Filter link; the comparator is synchronised inside the filter
   pcpt_ocp_if ocpLink();
   assign ocpLink.filterCode = protCfg_reg[pcpt_pkg::OCP_FILT_LSB +: 2]; // [RULE8]
   assign ocpLink.ocRaw = severeOcRaw;

   pcpt_deglitch u_deglitch (
      .clk(clk),
      .reset(reset),
      .ocp(ocpLink.filt)
   );
   // Soft-start delay sequencer; unused code 11 behaves as no delay
   function automatic logic [pcpt_pkg::SS_CNT_W-1:0] ss_delay(input logic [1:0] code);
      unique case (code)
         2'h1: ss_delay = pcpt_pkg::SS_CNT_W'(SS_STEP_CYCLES);
         2'h2: ss_delay = pcpt_pkg::SS_CNT_W'(2 * SS_STEP_CYCLES);
         default: ss_delay = '0;
      endcase
   endfunction : ss_delay
   pcpt_pkg::pcpt_ss_e ssState_reg, ssState_next;
   logic [pcpt_pkg::SS_CNT_W-1:0] ssCnt_reg, ssCnt_next;
   logic ssGo_reg, ssGo_next;

   always_comb begin
      ssState_next = ssState_reg;
      ssCnt_next = ssCnt_reg;
      ssGo_next = 1'b0;
      unique case (ssState_reg)
         pcpt_pkg::SS_IDLE: begin
            if (startReq) begin
               ssCnt_next = ss_delay(protCfg_reg[pcpt_pkg::SS_CFG_LSB +: 2]); // [RULE10]
               ssState_next = pcpt_pkg::SS_WAIT;
            end
         end
         pcpt_pkg::SS_WAIT: begin
            if (ssCnt_reg == '0) begin
               ssGo_next = 1'b1;
               ssState_next = pcpt_pkg::SS_IDLE;
            end else begin
               ssCnt_next = ssCnt_reg - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ssState_reg <= pcpt_pkg::SS_IDLE;
         ssCnt_reg <= '0;
         ssGo_reg <= 1'b0;
      end else begin
         ssState_reg <= ssState_next;
         ssCnt_reg <= ssCnt_next;
         ssGo_reg <= ssGo_next;
      end
   end
   assign rdData = rdData_reg;
   assign respValid = respValid_reg;
   assign respError = respError_reg;
   assign vinAvg = avg_reg[0];
   assign ioutAvg = avg_reg[1];
   assign pinAvg = avg_reg[2];
   assign iadcRun = !iadcDis; // [RULE9]
   assign severeOcTrip = ocpLink.trip;
   assign softStartGo = ssGo_reg;
   property p_cfg_reset;
      @(posedge clk) $fell(reset) |-> protCfg_reg == pcpt_pkg::PROT_CFG_RESET;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("Config not zero after reset"); // [RULE1]
   property p_avg_upper;
      @(posedge clk) disable iff (reset) avgCfg_reg[7:4] == 4'h0;
   endproperty
   a_avg_upper: assert property (p_avg_upper) else $error("Averaging upper bits nonzero"); // [RULE2]
   property p_clear;
      @(posedge clk) disable iff (reset)
      (clearPeaks && !sampleValid) |=> peak_reg == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("Peaks not cleared"); // [RULE5]
   property p_peak_mono;
      @(posedge clk) disable iff (reset)
      !clearPeaks |=> peak_reg[0] >= $past(peak_reg[0]) && peak_reg[3] >= $past(peak_reg[3]);
   endproperty
   a_peak_mono: assert property (p_peak_mono) else $error("Peak decreased"); // [RULE11]
   property p_iadc_freeze;
      @(posedge clk) disable iff (reset)
      (iadcDis && !clearPeaks) |=> $stable(peak_reg[1]) && $stable(avg_reg[2]);
   endproperty
   a_iadc_freeze: assert property (p_iadc_freeze) else $error("Current updated while off"); // [RULE12]
   property p_rd_peak;
      @(posedge clk) disable iff (reset)
      (cmdValid && !cmdWrite && cmdCode == pcpt_pkg::CMD_PEAK_TEMP)
      |=> respValid && !respError && rdData == {6'h00, $past(peak_reg[3])};
   endproperty
   a_rd_peak: assert property (p_rd_peak) else $error("Peak read wrong"); // [RULE6]
   property p_iadc_run;
      @(posedge clk) disable iff (reset)
      $past(cmdValid && cmdWrite && !cmdSendByte && cmdCode == pcpt_pkg::CMD_PROT_CFG)
      |-> iadcRun == !$past(cmdWrData[pcpt_pkg::IADC_DIS_BIT]);
   endproperty
   a_iadc_run: assert property (p_iadc_run) else $error("ADC enable wrong"); // [RULE9]
   property p_ss_zero;
      @(posedge clk) disable iff (reset)
      (ssState_reg == pcpt_pkg::SS_IDLE && startReq &&
       protCfg_reg[pcpt_pkg::SS_CFG_LSB +: 2] == 2'h0) |=> ##1 softStartGo;
   endproperty
   a_ss_zero: assert property (p_ss_zero) else $error("Zero soft-start delay late"); // [RULE10]
   property p_avg_done;
      @(posedge clk) disable iff (reset)
      (windowDone && avgShift == 4'h0) |=> vinAvg == $past(vinSample);
   endproperty
   a_avg_done: assert property (p_avg_done) else $error("Single-sample average wrong"); // [RULE3]
endmodule : pcpt_top

// ==== test/pcpt_host_model.sv ====
// Bus host model issuing decoded register commands to the device
`timescale 1ns/10ps
module pcpt_host_model (
   input wire logic clk, // Device clock
   output logic cmdValid, // Command strobe
   output logic cmdWrite, // Write or send byte
   output logic cmdSendByte, // Command without data
   output logic [7:0] cmdCode, // Command code
   output logic [15:0] cmdWrData, // Write data
   input wire logic [15:0] rdData, // Read data
   input wire logic respValid, // Answer strobe
   input wire logic respError // Refusal flag
);
   // Idle values at time zero
   initial begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdSendByte = 1'b0;
      cmdCode = 8'h00;
      cmdWrData = 16'h0000;
   end

   // One command; send byte carries no data
   // Write data goes out as given; averaging writes keep any upper nibble the test sets
   task automatic xfer(input logic w, input logic sb, input logic [7:0] code,
         input logic [15:0] d, output logic [15:0] rd, output logic err);
      int n;
      @(negedge clk);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdSendByte = sb;
      cmdCode = code;
      cmdWrData = sb ? ~cmdWrData : d;
      @(negedge clk);
      cmdValid = 1'b0;
      // Released lines toggle, so a stale value never looks valid
      cmdCode = ~cmdCode;
      cmdWrData = ~cmdWrData;
      n = 0;
      while (respValid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      rd = rdData;
      err = (respValid === 1'b1) ? respError : 1'bx;
   endtask : xfer

   // Host-side scaling of a raw reading
   function automatic real scale(input shortint y, input shortint m, input shortint b,
         input byte r);
      return (real'(y) * (10.0 ** (-r)) - real'(b)) / real'(m);
   endfunction : scale
endmodule : pcpt_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the peak telemetry register set
`timescale 1ns/10ps
module tb_top;
   localparam int SS_STEP = 20;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cmdValid, cmdWrite, cmdSendByte, respValid, respError;
   logic [7:0] cmdCode;
   logic [15:0] cmdWrData, rdData, rd;
   logic sampleValid = 1'b0;
   logic [9:0] vinSample = 10'h000;
   logic [9:0] ioutSample = 10'h000;
   logic [9:0] pinSample = 10'h000;
   logic [9:0] tempSample = 10'h000;
   logic [9:0] vinAvg, ioutAvg, pinAvg;
   logic iadcRun, severeOcTrip, softStartGo, err;
   logic severeOcRaw = 1'b0;
   logic startReq = 1'b0;
   int numErrors = 0;
   int samplesChecked = 0;
   int cycles = 0;

   always #2 clk = ~clk;

   pcpt_top #(.SS_STEP_CYCLES(SS_STEP)) i_pcpt_top (.clk(clk), .reset(reset),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdSendByte(cmdSendByte),
      .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rdData(rdData), .respValid(respValid),
      .respError(respError), .sampleValid(sampleValid), .vinSample(vinSample),
      .ioutSample(ioutSample), .pinSample(pinSample), .tempSample(tempSample),
      .vinAvg(vinAvg), .ioutAvg(ioutAvg), .pinAvg(pinAvg), .iadcRun(iadcRun),
      .severeOcRaw(severeOcRaw), .severeOcTrip(severeOcTrip), .startReq(startReq),
      .softStartGo(softStartGo));

   pcpt_host_model i_pcpt_host_model (.clk(clk), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdSendByte(cmdSendByte), .cmdCode(cmdCode),
      .cmdWrData(cmdWrData), .rdData(rdData), .respValid(respValid),
      .respError(respError));

   // Hang guard, well above the longest deglitch test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         numErrors++;
         complete_run();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rw(input logic w, input logic sb, input logic [7:0] code,
         input logic [15:0] d);
      i_pcpt_host_model.xfer(w, sb, code, d, rd, err);
   endtask : rw

   task automatic smp(input logic [9:0] v, input logic [9:0] i, input logic [9:0] p,
         input logic [9:0] t);
      @(negedge clk);
      sampleValid = 1'b1;
      vinSample = v;
      ioutSample = i;
      pinSample = p;
      tempSample = t;
      @(negedge clk);
      sampleValid = 1'b0;
      repeat (2) @(negedge clk);
   endtask : smp

   // Power-up values and cleared peaks
   task automatic t_reset();
      int scaled;
      // Host conversion: (100 * 10 - 50) / 5 = 190
      scaled = int'(i_pcpt_host_model.scale(16'h0064, 16'h0005, 16'h0032, 8'hff));
      check("scale", 16'(scaled), 16'h00be);
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h0000);
      check("cfg", rd, 16'h0000);
      check("run", 16'(iadcRun), 16'h0001);
      for (int c = 1; c < 5; c++) begin
         rw(1'b0, 1'b0, 8'(8'hd0 + c), 16'h0000);
         check("peak0", rd, 16'h0000);
      end
   endtask : t_reset

   // Upper nibble ignored, then a two-sample window
   task automatic t_avg();
      rw(1'b1, 1'b0, pcpt_pkg::CMD_AVG_CFG, 16'h00f0);
      smp(10'h005, 10'h003, 10'h002, 10'h001);
      check("avg1", 16'(vinAvg), 16'h0005);
      rw(1'b1, 1'b0, pcpt_pkg::CMD_AVG_CFG, 16'h0001);
      smp(10'h004, 10'h00a, 10'h002, 10'h001);
      smp(10'h008, 10'h014, 10'h004, 10'h001);
      check("avg2v", 16'(vinAvg), 16'h0006);
      check("avg2i", 16'(ioutAvg), 16'h000f);
      check("avg2p", 16'(pinAvg), 16'h0003);
      rw(1'b1, 1'b0, pcpt_pkg::CMD_AVG_CFG, 16'h0000);
   endtask : t_avg

   // Peaks keep the largest value, 10 bits zero-extended
   task automatic t_peaks();
      logic [15:0] exp [4];
      exp = '{16'h012c, 16'h00c8, 16'h0384, 16'h01f4};
      smp(10'h12c, 10'h0c8, 10'h384, 10'h1f4);
      smp(10'h064, 10'h032, 10'h03c, 10'h028);
      for (int c = 0; c < 4; c++) begin
         rw(1'b0, 1'b0, 8'(8'hd1 + c), 16'h0000);
         check("peak", rd, exp[c]);
         check("perr", 16'(err), 16'h0000);
      end
   endtask : t_peaks

   // Clear command, then refused commands
   task automatic t_clear();
      rw(1'b1, 1'b1, pcpt_pkg::CMD_PEAK_RESET, 16'h0000);
      check("clrerr", 16'(err), 16'h0000);
      for (int c = 1; c < 5; c++) begin
         rw(1'b0, 1'b0, 8'(8'hd0 + c), 16'h0000);
         check("clr", rd, 16'h0000);
      end
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PEAK_RESET, 16'h0000);
      check("rdd5", 16'(err), 16'h0001);
      rw(1'b1, 1'b1, pcpt_pkg::CMD_PEAK_VIN, 16'h0000);
      check("sbd1", 16'(err), 16'h0001);
   endtask : t_clear

   // Current ADC off freezes current and power
   task automatic t_iadc();
      logic [9:0] oldI, oldP;
      rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h2000);
      check("run0", 16'(iadcRun), 16'h0000);
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h0000);
      check("cfgrd", rd, 16'h2000);
      oldI = ioutAvg;
      oldP = pinAvg;
      smp(10'h007, 10'h190, 10'h190, 10'h009);
      check("iavg", 16'(ioutAvg), 16'(oldI));
      check("pavg", 16'(pinAvg), 16'(oldP));
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PEAK_IOUT, 16'h0000);
      check("ipk", rd, 16'h0000);
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PEAK_VIN, 16'h0000);
      check("vpk", rd, 16'h0007);
      rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h0000);
      check("run1", 16'(iadcRun), 16'h0001);
   endtask : t_iadc

   // Reset in mid-run clears configuration and peaks
   task automatic t_rst2();
      rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h2000);
      smp(10'h0aa, 10'h000, 10'h000, 10'h055);
      reset = 1'b1;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      check("run2", 16'(iadcRun), 16'h0001);
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PEAK_TEMP, 16'h0000);
      check("tpk2", rd, 16'h0000);
      rw(1'b0, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h0000);
      check("cfg2", rd, 16'h0000);
   endtask : t_rst2

   // Deglitch per code; a short pulse must not trip
   task automatic t_ocp();
      int hold [4];
      int n;
      hold = '{0, 250, 500, 2500};
      for (int c = 0; c < 4; c++) begin
         rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, {2'(c), 14'h0000});
         severeOcRaw = 1'b1;
         n = 0;
         while (severeOcTrip !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         check("tripwin", 16'(n >= hold[c] + 2 && n <= hold[c] + 9), 16'h0001);
         severeOcRaw = 1'b0;
         repeat (8) @(negedge clk);
         check("tripoff", 16'(severeOcTrip), 16'h0000);
      end
      rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, 16'h8000);
      severeOcRaw = 1'b1;
      repeat (400) @(negedge clk);
      severeOcRaw = 1'b0;
      check("short", 16'(severeOcTrip), 16'h0000);
   endtask : t_ocp

   // Soft-start delay per code
   task automatic t_ss();
      int dly [4];
      int n;
      dly = '{0, SS_STEP, 2 * SS_STEP, 0};
      for (int c = 0; c < 4; c++) begin
         rw(1'b1, 1'b0, pcpt_pkg::CMD_PROT_CFG, {3'h0, 2'(c), 11'h000});
         startReq = 1'b1;
         @(negedge clk);
         startReq = 1'b0;
         n = 0;
         while (softStartGo !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         check("ssdly", 16'(n + 1), 16'(dly[c] + 2));
      end
   endtask : t_ss

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // Reset for five cycles, then the scenarios in order
   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_reset();
      t_avg();
      t_peaks();
      t_clear();
      t_iadc();
      t_rst2();
      t_ocp();
      t_ss();
      complete_run();
   end
endmodule : tb_top
